// file: verification/adcc_front_model.sv
`timescale 1ns/1ps
module adcc_front_model (
    input  wire logic [9:0] dacCode,
    input  wire logic [9:0] level,
    output logic            cmpHigh
);
    // Ideal comparator; no offset or noise, so results are exact
    assign cmpHigh = (level >= dacCode);
endmodule : adcc_front_model

// file: verification/adcc_monitor.sv
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_monitor
    import adcc_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input wire logic              core_clk,
    input wire logic              arst_n,
    input wire logic              ce,
    input wire logic              lowPowerHold,
    input wire logic [9:0]        dacCode,
    input wire logic [3:0]        input_channel_select,
    input wire logic              irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready
);
    localparam logic [ADDR_W-1:0] AMODE = ADDR_W'(`ADCC_IDX_MODE * 4);
    localparam logic [ADDR_W-1:0] ASTOP = ADDR_W'(`ADCC_IDX_CLK_STOP_1 * 4);
    localparam logic [ADDR_W-1:0] AEN   = ADDR_W'(`ADCC_IDX_IRQ_ENABLE * 4);
    localparam logic [ADDR_W-1:0] ACLR  = ADDR_W'(`ADCC_IDX_IRQ_CLEAR * 4);
    logic wrTake;
    logic inStandby_ff;
    assign wrTake = s_axi_awready && ce && s_axi_wstrb[0];
    // Standby bit is not a port, so mirror it from the bus
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            inStandby_ff <= 1'b0;
        end else if (wrTake && s_axi_awaddr == ASTOP) begin
            inStandby_ff <= !s_axi_wdata[`ADCC_STANDBY_BIT];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_rst_quiet;
        $rose(arst_n) |-> !irq && dacCode == 10'h000 && input_channel_select == 4'h0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle after reset");
    property p_hold_mode;
        wrTake && s_axi_awaddr == AMODE && lowPowerHold |=> $stable(input_channel_select);
    endproperty
    a_hold_mode: assert property (p_hold_mode) else $error("mode written during hold");
    property p_stby_mode;
        wrTake && s_axi_awaddr == AMODE && inStandby_ff |=> $stable(input_channel_select);
    endproperty
    a_stby_mode: assert property (p_stby_mode) else $error("mode written in standby");
    property p_ce_freeze;
        !ce |=> $stable(dacCode) && $stable(irq) && $stable(input_channel_select);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with ce low");
    property p_irq_clear;
        wrTake && s_axi_awaddr == ACLR && s_axi_wdata[0] |-> ##2 !irq [*2];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq kept after clear");
    property p_irq_mask;
        wrTake && s_axi_awaddr == AEN && !s_axi_wdata[0] |-> ##2 !irq [*3];
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq raised while disabled");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped before bready");
    property p_aw_walk;
        s_axi_awready && ce |=> !s_axi_awready && s_axi_bvalid;
    endproperty
    a_aw_walk: assert property (p_aw_walk) else $error("write response not after accept");
endmodule : adcc_monitor
bind adcc_top adcc_monitor #(.ADDR_W(ADDR_W)) mon_u (.core_clk, .arst_n, .ce, .lowPowerHold,
    .dacCode, .input_channel_select, .irq, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_awready, .s_axi_bvalid, .s_axi_bready);

// file: verification/adcc_tb.sv
`timescale 1ns/1ps
`include "adcc_defines.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
    logic        core_clk = 1'b0;
    logic        arst_n, ce, lowPowerHold, external_trigger_pin, cmpHigh, irq;
    logic [9:0]  level, dacCode;
    logic [3:0]  input_channel_select, s_axi_wstrb;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          t0;
    adcc_top dut_u (.core_clk, .arst_n, .ce, .lowPowerHold, .cmpHigh, .external_trigger_pin,
        .dacCode, .input_channel_select, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    adcc_front_model fe_u (.dacCode, .level, .cmpHigh);
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 0);
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                `CHK("bresp", er, s_axi_bresp)
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er = 0);
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                `CHK($sformatf("read %0h", idx), {24'h0, e}, s_axi_rdata)
                `CHK("rresp", er, s_axi_rresp)
            end
        end while (s_axi_arvalid || s_axi_rready);
    endtask : rd
    task automatic waitIrq(input int lo, input int hi);
        while (irq !== 1'b1 && cyc - t0 < 200) @(posedge core_clk);
        `CHK("irq delay", 1'b1, (cyc - t0 >= lo) && (cyc - t0 <= hi))
    endtask : waitIrq
    initial begin
        {arst_n, lowPowerHold, external_trigger_pin, s_axi_awvalid, s_axi_wvalid} = 0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
        {ce, s_axi_wdata, s_axi_wstrb, level} = {1'b1, 32'h0, 4'hF, 10'h2A5};
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`ADCC_IDX_MODE, 8'h30);
        rd(`ADCC_IDX_START, 8'h7F);
        rd(`ADCC_IDX_CLK_STOP_1, 8'hFF);
        rd(16'h0200, 8'h00, 2'b10);
        wr(16'h0200, 8'h00, 2'b10);
        wr(`ADCC_IDX_IRQ_ENABLE, 8'h01);
        for (int s = 0; s < 2; s++) begin
            level <= s ? 10'h15A : 10'h2A5;
            wr(`ADCC_IDX_MODE, {s[0], 7'h05});
            rd(`ADCC_IDX_MODE, {s[0], 7'h35});
            `CHK("channel", 4'h5, input_channel_select)
            wr(`ADCC_IDX_START, 8'h80);
            t0 = cyc;
            rd(`ADCC_IDX_START, 8'hFF);
            waitIrq(s ? 28 : 59, s ? 36 : 67);
            rd(`ADCC_IDX_START, 8'h7F);
            rd(`ADCC_IDX_RESULT_HI, level[9:2]);
            rd(`ADCC_IDX_RESULT_LO, {level[1:0], 6'h00});
            rd(`ADCC_IDX_IRQ_STATUS, 8'h01);
            wr(`ADCC_IDX_IRQ_CLEAR, 8'h01);
            rd(`ADCC_IDX_IRQ_STATUS, 8'h00);
        end
        // Stopped conversion must leave the old result
        level <= 10'h3FF;
        wr(`ADCC_IDX_START, 8'h80);
        repeat (10) @(posedge core_clk);
        wr(`ADCC_IDX_START, 8'h00);
        repeat (80) @(posedge core_clk);
        rd(`ADCC_IDX_IRQ_STATUS, 8'h00);
        rd(`ADCC_IDX_RESULT_HI, 8'h56);
        wr(`ADCC_IDX_IRQ_ENABLE, 8'h00);
        wr(`ADCC_IDX_START, 8'h80);
        repeat (70) @(posedge core_clk);
        `CHK("irq masked", 1'b0, irq)
        rd(`ADCC_IDX_IRQ_STATUS, 8'h01);
        rd(`ADCC_IDX_RESULT_HI, 8'hFF);
        wr(`ADCC_IDX_IRQ_ENABLE, 8'h01);
        // Irq is registered, so it follows the enable one edge later
        @(posedge core_clk);
        `CHK("irq unmasked", 1'b1, irq)
        wr(`ADCC_IDX_IRQ_ENABLE, 8'h00);
        @(posedge core_clk);
        `CHK("irq remasked", 1'b0, irq)
        for (int k = 0; k < 5; k++) begin
            wr(`ADCC_IDX_IRQ_CLEAR, 8'h01);
            wr(`ADCC_IDX_EDGE_SELECT, {7'h0, k < 4});
            wr(`ADCC_IDX_PORT_MODE_1, {7'h0, k[0] | k[2]});
            wr(`ADCC_IDX_MODE, {1'b1, k[1] | k[2], 6'h05});
            external_trigger_pin <= (k == 4);
            repeat (3) @(posedge core_clk);
            external_trigger_pin <= (k != 4);
            repeat (60) @(posedge core_clk);
            rd(`ADCC_IDX_IRQ_STATUS, {7'h0, k >= 3});
        end
        wr(`ADCC_IDX_IRQ_CLEAR, 8'h01);
        wr(`ADCC_IDX_CLK_STOP_1, 8'hEF);
        rd(`ADCC_IDX_CLK_STOP_1, 8'hEF);
        wr(`ADCC_IDX_START, 8'h80);
        rd(`ADCC_IDX_START, 8'h7F);
        wr(`ADCC_IDX_MODE, 8'h8A);
        `CHK("channel standby", 4'h5, input_channel_select)
        external_trigger_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        external_trigger_pin <= 1'b0;
        repeat (60) @(posedge core_clk);
        rd(`ADCC_IDX_IRQ_STATUS, 8'h00);
        wr(`ADCC_IDX_CLK_STOP_1, 8'hFF);
        repeat (10) @(posedge core_clk);
        lowPowerHold <= 1'b1;
        wr(`ADCC_IDX_MODE, 8'h8A);
        `CHK("channel hold", 4'h5, input_channel_select)
        lowPowerHold <= 1'b0;
        wr(`ADCC_IDX_IRQ_ENABLE, 8'h01);
        wr(`ADCC_IDX_START, 8'h80);
        lowPowerHold <= 1'b1;
        repeat (60) @(posedge core_clk);
        `CHK("irq in hold", 1'b0, irq)
        // Hold drops with ce, so only ce keeps the running converter still
        ce <= 1'b0;
        lowPowerHold <= 1'b0;
        repeat (5) @(posedge core_clk);
        ce <= 1'b1;
        t0 = cyc;
        waitIrq(20, 38);
        wr(`ADCC_IDX_START, 8'h80);
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`ADCC_IDX_MODE, 8'h30);
        rd(`ADCC_IDX_START, 8'h7F);
        rd(`ADCC_IDX_RESULT_HI, 8'hFF);
        print_verdict();
    end
endmodule : tb

// file: verilog/adcc_defines.svh
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Register indices; byte address is four times the index
`define ADCC_IDX_RESULT_HI    16'hFFC4
`define ADCC_IDX_RESULT_LO    16'hFFC5
`define ADCC_IDX_MODE         16'hFFC6
`define ADCC_IDX_START        16'hFFC7
`define ADCC_IDX_CLK_STOP_1   16'hFFFA
`define ADCC_IDX_IRQ_STATUS   16'h0100
`define ADCC_IDX_IRQ_ENABLE   16'h0101
`define ADCC_IDX_IRQ_CLEAR    16'h0102
`define ADCC_IDX_PORT_MODE_1  16'h0103
`define ADCC_IDX_EDGE_SELECT  16'h0104

// Field positions
`define ADCC_MODE_SPEED_BIT   7
`define ADCC_MODE_TRIG_BIT    6
`define ADCC_START_FLAG_BIT   7
`define ADCC_STANDBY_BIT      4
`define ADCC_CONV_END_BIT     0
`define ADCC_PIN_FUNC_BIT     0
`define ADCC_EDGE_SEL_BIT     0

// Reset values
`define ADCC_MODE_RESET       8'h30
`define ADCC_START_RESET      8'h7F
`define ADCC_CLK_STOP_RESET   8'hFF

// Conversion periods in system clocks, and one trial length per speed
`define ADCC_PERIOD_SLOW      6'd62
`define ADCC_PERIOD_FAST      6'd31
`define ADCC_TRIAL_SLOW       3'd6
`define ADCC_TRIAL_FAST       3'd3

`endif

// file: verilog/adcc_if.sv
`timescale 1ns/1ps
interface adcc_if;
    logic       startReq;
    logic       stopReq;
    logic       fast;
    logic       hold;
    logic       busy;
    logic       done;
    logic [9:0] result;

    modport ctrl (output startReq, output stopReq, output fast, output hold,
                  input busy, input done, input result);
    modport sar  (input startReq, input stopReq, input fast, input hold,
                  output busy, output done, output result);
endinterface : adcc_if

// file: verilog/adcc_pkg.sv
package adcc_pkg;

    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b01,
        ADCC_RUN  = 2'b10
    } adcc_state_e;

    typedef logic [1:0] adcc_resp_t;

endpackage : adcc_pkg

// file: verilog/adcc_sar.sv
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_sar
    import adcc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic cmpHigh,
    output logic [9:0] dacCode,
    adcc_if.sar       ctl
);
    adcc_state_e state_ff;
    logic [5:0]  cnt_ff;
    logic [2:0]  phase_ff;
    logic [3:0]  bitIdx_ff;
    logic        trialsDone_ff;
    logic        done_ff;
    logic [9:0]  result_ff;
    logic [5:0]  periodLast;
    logic [2:0]  trialLast;

    assign periodLast = (ctl.fast ? `ADCC_PERIOD_FAST : `ADCC_PERIOD_SLOW) - 6'd1;
    assign trialLast  = (ctl.fast ? `ADCC_TRIAL_FAST : `ADCC_TRIAL_SLOW) - 3'd1;
    assign ctl.busy   = (state_ff == ADCC_RUN);
    assign ctl.done   = done_ff;
    assign ctl.result = result_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff      <= ADCC_IDLE;
            cnt_ff        <= 6'd0;
            phase_ff      <= 3'd0;
            bitIdx_ff     <= 4'd9;
            trialsDone_ff <= 1'b0;
            done_ff       <= 1'b0;
            dacCode       <= 10'h000;
        end else if (ce && !ctl.hold) begin
            done_ff <= 1'b0;
            unique case (state_ff)
                ADCC_IDLE: begin
                    if (ctl.startReq) begin
                        state_ff      <= ADCC_RUN;
                        cnt_ff        <= 6'd0;
                        phase_ff      <= 3'd0;
                        bitIdx_ff     <= 4'd9;
                        trialsDone_ff <= 1'b0;
                        dacCode       <= 10'h200;
                    end
                end
                ADCC_RUN: begin
                    if (ctl.stopReq) begin
                        state_ff <= ADCC_IDLE;
                    end else if (cnt_ff == periodLast) begin
                        state_ff <= ADCC_IDLE;
                        done_ff  <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff + 6'd1;
                        if (!trialsDone_ff) begin
                            phase_ff <= (phase_ff == trialLast) ? 3'd0 : phase_ff + 3'd1;
                        end
                        if (!trialsDone_ff && phase_ff == trialLast) begin
                            if (bitIdx_ff == 4'd0) begin
                                trialsDone_ff <= 1'b1;
                                dacCode <= cmpHigh ? dacCode : (dacCode & ~10'h001);
                            end else begin
                                dacCode <= (cmpHigh ? dacCode
                                                    : (dacCode & ~(10'h001 << bitIdx_ff)))
                                           | (10'h001 << (bitIdx_ff - 4'd1));
                                bitIdx_ff <= bitIdx_ff - 4'd1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Result is data, so it keeps its value through reset
    always_ff @(posedge core_clk) begin
        if (ce && !ctl.hold && state_ff == ADCC_RUN && !ctl.stopReq
            && cnt_ff == periodLast) begin
            result_ff <= dacCode;
        end
    end
endmodule : adcc_sar

// file: verilog/adcc_top.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "adcc_defines.svh"
// Behaviour
// - Standby bit 4: 0 standby, resets 1
// - Successive approximation giving 10-bit results
// - Writing start flag 1 begins conversion
// - Start flag 1 during conversion, self-clears
// - Conversion end sets request flag
// - Interrupt only while end enable is 1
// - Trigger needs pin function and enable
// - Selected trigger edge sets flag, starts
// - Mode, start reset; results survive reset
// - Low-power and standby modes hold mode register and converter
// - Result stored as flag clears, idle
// - Upper 8 bits high, lower 2 low
// - Writing 0 to start flag stops conversion
// - Speed bit: 62 or 31 clocks
module adcc_top
    import adcc_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              ce,
    input  wire logic              lowPowerHold,
    input  wire logic              cmpHigh,
    input  wire logic              external_trigger_pin,
    output logic       [9:0]       dacCode,
    output logic       [3:0]       input_channel_select,
    output logic                   irq,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    localparam adcc_resp_t RESP_OKAY   = 2'b00;
    localparam adcc_resp_t RESP_SLVERR = 2'b10;

    adcc_if conv ();

    // Register state
    logic       speedFast_ff;
    logic       trigEnable_ff;
    logic [7:0] clockStop_ff;
    logic       pinFunc_ff;
    logic       edgeRising_ff;
    logic       irqStatus_ff;
    logic       irqEnable_ff;

    // Bus handshake state
    logic       wrFire;
    logic       rdFire;
    logic [15:0] wrIdx;
    logic [15:0] rdIdx;
    logic       wrLane0;
    logic [7:0] wrByte;
    logic       wrHit;
    logic       rdHit;
    logic [7:0] rdByte;

    // Converter control
    logic       standby;
    logic       freeze;
    logic       trigPulse;
    logic       swStart;
    logic       swStop;
    logic       busyPrev_ff;

    assign standby = ~clockStop_ff[`ADCC_STANDBY_BIT];
    // Clock-stop register itself stays reachable so standby can be left again
    assign freeze  = lowPowerHold | standby;

    // ---------------- AXI4-Lite write channel ----------------
    assign wrFire  = s_axi_awready;
    assign wrIdx   = s_axi_awaddr[17:2];
    assign wrLane0 = s_axi_wstrb[0];
    assign wrByte  = s_axi_wdata[7:0];

    always_comb begin
        unique case (wrIdx)
            `ADCC_IDX_RESULT_HI,
            `ADCC_IDX_RESULT_LO,
            `ADCC_IDX_MODE,
            `ADCC_IDX_START,
            `ADCC_IDX_CLK_STOP_1,
            `ADCC_IDX_IRQ_STATUS,
            `ADCC_IDX_IRQ_ENABLE,
            `ADCC_IDX_IRQ_CLEAR,
            `ADCC_IDX_PORT_MODE_1,
            `ADCC_IDX_EDGE_SELECT: wrHit = 1'b1;
            default:               wrHit = 1'b0;
        endcase
    end

    // Address and data are taken together, one edge, once both are offered
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else if (ce) begin
            s_axi_awready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
            s_axi_wready  <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---------------- AXI4-Lite read channel ----------------
    assign rdFire = s_axi_arready;
    assign rdIdx  = s_axi_araddr[17:2];

    always_comb begin
        rdHit  = 1'b1;
        rdByte = 8'h00;
        unique case (rdIdx)
            `ADCC_IDX_RESULT_HI:   rdByte = conv.result[9:2];
            `ADCC_IDX_RESULT_LO:   rdByte = {conv.result[1:0], 6'b00_0000};
            `ADCC_IDX_MODE:        rdByte = {speedFast_ff, trigEnable_ff, 2'b11,
                                             input_channel_select};
            `ADCC_IDX_START:       rdByte = {conv.busy, 7'h7F};
            `ADCC_IDX_CLK_STOP_1:  rdByte = clockStop_ff;
            `ADCC_IDX_IRQ_STATUS:  rdByte = {7'h00, irqStatus_ff};
            `ADCC_IDX_IRQ_ENABLE:  rdByte = {7'h00, irqEnable_ff};
            `ADCC_IDX_IRQ_CLEAR:   rdByte = 8'h00;
            `ADCC_IDX_PORT_MODE_1: rdByte = {7'h00, pinFunc_ff};
            `ADCC_IDX_EDGE_SELECT: rdByte = {7'h00, edgeRising_ff};
            default:               rdHit  = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
        end else if (ce) begin
            s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rdByte};
                s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------- Mode register ----------------
    // Held in low power and standby; settings changes mid-run are software's care
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            speedFast_ff         <= 1'(`ADCC_MODE_RESET >> `ADCC_MODE_SPEED_BIT);
            trigEnable_ff        <= 1'b0;
            input_channel_select <= 4'h0;
        end else if (ce && !freeze && wrFire && wrLane0 && wrIdx == `ADCC_IDX_MODE) begin
            speedFast_ff         <= wrByte[`ADCC_MODE_SPEED_BIT];
            trigEnable_ff        <= wrByte[`ADCC_MODE_TRIG_BIT];
            input_channel_select <= wrByte[3:0];
        end
    end

    // ---------------- Clock stop and pin control ----------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clockStop_ff <= `ADCC_CLK_STOP_RESET;
        end else if (ce && wrFire && wrLane0 && wrIdx == `ADCC_IDX_CLK_STOP_1) begin
            clockStop_ff <= wrByte;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinFunc_ff    <= 1'b0;
            edgeRising_ff <= 1'b0;
        end else if (ce && wrFire && wrLane0) begin
            if (wrIdx == `ADCC_IDX_PORT_MODE_1) begin
                pinFunc_ff <= wrByte[`ADCC_PIN_FUNC_BIT];
            end
            if (wrIdx == `ADCC_IDX_EDGE_SELECT) begin
                edgeRising_ff <= wrByte[`ADCC_EDGE_SEL_BIT];
            end
        end
    end

    // ---------------- Start and stop ----------------
    assign swStart = wrFire && wrLane0 && wrIdx == `ADCC_IDX_START
                     && wrByte[`ADCC_START_FLAG_BIT];
    assign swStop  = wrFire && wrLane0 && wrIdx == `ADCC_IDX_START
                     && !wrByte[`ADCC_START_FLAG_BIT];

    adcc_trig u_trig (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .trigPin   (external_trigger_pin),
        .risingSel (edgeRising_ff),
        .enable    (pinFunc_ff & trigEnable_ff),
        .trigPulse (trigPulse)
    );

    // Standby and low power block both start sources
    assign conv.startReq = ~freeze & (swStart | trigPulse);
    assign conv.stopReq  = swStop;
    assign conv.fast     = speedFast_ff;
    assign conv.hold     = freeze;

    adcc_sar u_sar (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .cmpHigh  (cmpHigh),
        .dacCode  (dacCode),
        .ctl      (conv)
    );

    // ---------------- Interrupt ----------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busyPrev_ff <= 1'b0;
        end else if (ce) begin
            busyPrev_ff <= conv.busy;
        end
    end

    // Set wins over a clear in the same cycle so no end event is lost
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStatus_ff <= 1'b0;
        end else if (ce) begin
            if (conv.done) begin
                irqStatus_ff <= 1'b1;
            end else if (wrFire && wrLane0 && wrIdx == `ADCC_IDX_IRQ_CLEAR
                         && wrByte[`ADCC_CONV_END_BIT]) begin
                irqStatus_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqEnable_ff <= 1'b0;
        end else if (ce && wrFire && wrLane0 && wrIdx == `ADCC_IDX_IRQ_ENABLE) begin
            irqEnable_ff <= wrByte[`ADCC_CONV_END_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= irqEnable_ff & (irqStatus_ff | conv.done);
        end
    end

endmodule : adcc_top

// file: verilog/adcc_trig.sv
`timescale 1ns/1ps
module adcc_trig
    import adcc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic trigPin,
    input  wire logic risingSel,
    input  wire logic enable,
    output logic      trigPulse
);
    logic pinPrev_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinPrev_ff <= 1'b0;
            trigPulse  <= 1'b0;
        end else if (ce) begin
            pinPrev_ff <= trigPin;
            trigPulse  <= enable & (risingSel ? (trigPin & ~pinPrev_ff)
                                              : (~trigPin & pinPrev_ff));
        end
    end
endmodule : adcc_trig
